// file: design/pdc_defines.svh
// register offsets, field positions and reset values of the pll configuration bank
// assumes byte addressing on a 32-bit axi4-lite bus, one register per aligned word
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH

// printed offsets such as 8'h55 are not multiples of four: they are indices, byte address is index * 4
`define PDC_IDX_REF_LOW     8'h54
`define PDC_IDX_OUT_REF_HI  8'h55
`define PDC_IDX_PRE_LOW     8'h56
`define PDC_IDX_PRE_HI      8'h57
`define PDC_IDX_PUMP        8'h58
`define PDC_IDX_EN1         8'h59
`define PDC_IDX_RES         8'h5a
`define PDC_IDX_CAP3        8'h5b
// status register of our own: effective ratios
`define PDC_IDX_STATUS      8'h60

// reset values of the whole bytes, factory bits included
`define PDC_RST_REF_LOW     8'h00
`define PDC_RST_OUT_REF_HI  8'h44
`define PDC_RST_PRE_LOW     8'h78
`define PDC_RST_PRE_HI      8'h40
`define PDC_RST_PUMP        8'h12
`define PDC_RST_EN1         8'h41
`define PDC_RST_RES         8'h2f
`define PDC_RST_CAP3        8'h27

// field positions
`define PDC_EN1_REFDIV_BIT  4
`define PDC_EN1_PLL_BIT     1
`define PDC_PUMP_BIAS_BIT   4
`define PDC_CLKSEL_BIT      4

// implemented-bit masks: bit 7 of the enable, resistor and cap registers reads zero
`define PDC_MASK_FULL       8'hff
`define PDC_MASK_LOW7       8'h7f

// axi responses
`define PDC_RESP_OKAY       2'b00
`define PDC_RESP_SLVERR     2'b10

`endif

// file: design/pdc_pkg.sv
// types of the pll configuration bank
// assumes pdc_defines.svh for numeric constants
package pdc_pkg;

  // decoded pll configuration handed to the analog side
  typedef struct packed {
    logic [9:0]  ref_ratio;        // effective reference divide ratio
    logic        ref_bypass;       // reference divider bypassed
    logic [3:0]  vco_post_ratio;   // effective output divide ratio, 0 means 1
    logic [11:0] fb_ratio;         // effective feedback prescale ratio
    logic        bias_self;        // charge-pump self-bias from analog supply
    logic [3:0]  pump_current_code;
    logic [4:0]  filter_resistor_code;
    logic [4:0]  series_cap_code;
    logic        pll_on;
  } pdc_cfg_t;

  typedef enum logic [1:0] {
    PDC_W_IDLE = 2'b00,
    PDC_W_RESP = 2'b01
  } pdc_wstate_t;

endpackage

// file: design/pdc_pll_config_bank.sv
// axi4-lite register bank holding the pll divider and loop settings
// assumes one clock aclk, synchronous active-low reset, analog pll outside
//
// Chosen here: the AXI4-Lite register port.
`include "pdc_defines.svh"

// Function
// [RQ1] ten-bit reference code: low byte, top two bits in bits 1-0 next register
// [RQ2] reference codes 3..1023 divide by code; codes 0 and 1 divide by one
// [RQ3] reference code 2 unsupported; has no effect, previous ratio kept
// [RQ4] reference divider acts only when enable bit 4 set; bypassed at reset
// [RQ5] reference divider sits on external clock before phase detector
// [RQ6] output divider bits 7-4 divide vco by code, 0 passes, reset 4
// [RQ7] twelve-bit prescaler: low byte plus four low bits of next register
// [RQ8] prescaler divides by 2..4095, codes 0 and 1 divide by one, reset 120
// [RQ9] bias bit 4: one self-bias from supply (reset), zero bandgap
// [RQ10] four-bit pump current code, about 25 ua per step, reset 0010
// [RQ11] enable register bit 1 switches pll on; off at reset
// [RQ12] five-bit filter resistor code rises linearly, reset 01111
// [RQ13] five-bit series capacitor code rises linearly, reset 00111
// [RQ14] software keeps factory bits at reset value when writing user fields
// [RQ15] bit 7 of enable, resistor and cap registers reads zero
// [RQ16] software picks pump, resistor, capacitor codes from comparison frequency
// [RQ17] timing from pll output when clock-source select one, else external clock
// [RQ18] software sets output, bias and pll enables before pll clock usable
// [RQ19] all fields take defaults at reset and hold writes until rewritten
module pdc_pll_config_bank (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [11:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [11:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             clk_source_sel,
  output pdc_pkg::pdc_cfg_t     pll_cfg,
  output logic                  timing_from_pll
);

  logic [7:0]  ref_low_q, out_ref_hi_q, pre_low_q, pre_hi_q;
  logic [7:0]  pump_q, en1_q, res_q, cap3_q;
  logic [9:0]  ref_ratio_q;
  logic [11:0] ref_ratio_full;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        aw_have_q, w_have_q;
  pdc_pkg::pdc_wstate_t wstate_q;
  logic [1:0]  bresp_q;
  logic        bvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        rvalid_q;
  logic        do_write;
  logic [7:0]  widx;

  // map a byte address onto a register index; misaligned gives an impossible index
  function automatic logic [7:0] addr_to_idx(input logic [11:0] a);
    // bits above the decoded range must be zero, so no alias hits a register
    if (a[1:0] != 2'b00 || a[11:10] != 2'b00) begin
      addr_to_idx = 8'hff;
    end else begin
      addr_to_idx = a[9:2];
    end
  endfunction

  // true when the index names a register of this bank
  function automatic logic idx_known(input logic [7:0] i);
    idx_known = (i >= `PDC_IDX_REF_LOW && i <= `PDC_IDX_CAP3) ||
                (i == `PDC_IDX_STATUS);
  endfunction

  // ten or twelve bit code into a ratio: 0 and 1 both mean one
  function automatic logic [11:0] code_to_ratio(input logic [11:0] c);
    code_to_ratio = (c < 12'h002) ? 12'h001 : c;
  endfunction

  // address and data captured independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  // one write at a time: no new beats accepted until the response is taken
  assign s_axi_awready = !aw_have_q && (wstate_q == pdc_pkg::PDC_W_IDLE);
  assign s_axi_wready  = !w_have_q && (wstate_q == pdc_pkg::PDC_W_IDLE);
  assign do_write      = aw_have_q && w_have_q && (wstate_q == pdc_pkg::PDC_W_IDLE);
  assign widx          = addr_to_idx(aw_addr_q);

  // write response state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_q <= pdc_pkg::PDC_W_IDLE;
      bvalid_q <= 1'b0;
      bresp_q  <= `PDC_RESP_OKAY;
    end else begin
      unique case (wstate_q)
        pdc_pkg::PDC_W_IDLE: begin
          if (do_write) begin
            wstate_q <= pdc_pkg::PDC_W_RESP;
            bvalid_q <= 1'b1;
            bresp_q  <= (idx_known(widx) && widx != `PDC_IDX_STATUS) ?
                        `PDC_RESP_OKAY : `PDC_RESP_SLVERR;
          end
        end
        pdc_pkg::PDC_W_RESP: begin
          if (s_axi_bready) begin
            wstate_q <= pdc_pkg::PDC_W_IDLE;
            bvalid_q <= 1'b0;
          end
        end
      endcase
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // configuration bytes; factory bits are stored as written, software keeps them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin // see [RQ19]
      ref_low_q    <= `PDC_RST_REF_LOW;
      out_ref_hi_q <= `PDC_RST_OUT_REF_HI; // see [RQ6]
      pre_low_q    <= `PDC_RST_PRE_LOW;    // see [RQ8]
      pre_hi_q     <= `PDC_RST_PRE_HI;
      pump_q       <= `PDC_RST_PUMP;       // see [RQ9] see [RQ10]
      en1_q        <= `PDC_RST_EN1;        // see [RQ4] see [RQ11]
      res_q        <= `PDC_RST_RES;        // see [RQ12]
      cap3_q       <= `PDC_RST_CAP3;       // see [RQ13]
    end else if (do_write && w_strb_q[0]) begin
      unique case (widx)
        `PDC_IDX_REF_LOW:    ref_low_q    <= w_data_q[7:0];
        `PDC_IDX_OUT_REF_HI: out_ref_hi_q <= w_data_q[7:0];
        `PDC_IDX_PRE_LOW:    pre_low_q    <= w_data_q[7:0];
        `PDC_IDX_PRE_HI:     pre_hi_q     <= w_data_q[7:0];
        `PDC_IDX_PUMP:       pump_q       <= w_data_q[7:0];
        `PDC_IDX_EN1:        en1_q        <= w_data_q[7:0] & `PDC_MASK_LOW7; // see [RQ15]
        `PDC_IDX_RES:        res_q        <= w_data_q[7:0] & `PDC_MASK_LOW7; // see [RQ15]
        `PDC_IDX_CAP3:       cap3_q       <= w_data_q[7:0] & `PDC_MASK_LOW7; // see [RQ15]
        default:             ;
      endcase
    end
  end

  // ratio of the current code, top bits always zero for a ten-bit code
  assign ref_ratio_full = code_to_ratio({2'b00, out_ref_hi_q[1:0], ref_low_q}); // see [RQ1]

  // effective reference ratio; code 2 leaves the last legal ratio in force
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_ratio_q <= 10'h001;
    end else if ({out_ref_hi_q[1:0], ref_low_q} != 10'h002) begin // see [RQ3]
      ref_ratio_q <= ref_ratio_full[9:0]; // see [RQ2]
    end
  end

  // decoded settings for the analog pll; outputs only reflect flip-flops
  always_comb begin
    pll_cfg.ref_bypass           = !en1_q[`PDC_EN1_REFDIV_BIT]; // see [RQ4]
    pll_cfg.ref_ratio            = pll_cfg.ref_bypass ? 10'h001 : ref_ratio_q; // see [RQ5]
    pll_cfg.vco_post_ratio       = out_ref_hi_q[7:4]; // see [RQ6]
    pll_cfg.fb_ratio             = code_to_ratio({pre_hi_q[3:0], pre_low_q}); // see [RQ7] see [RQ8]
    pll_cfg.bias_self            = pump_q[`PDC_PUMP_BIAS_BIT]; // see [RQ9]
    pll_cfg.pump_current_code    = pump_q[3:0]; // see [RQ10]
    pll_cfg.filter_resistor_code = res_q[4:0]; // see [RQ12]
    pll_cfg.series_cap_code      = cap3_q[4:0]; // see [RQ13]
    pll_cfg.pll_on               = en1_q[`PDC_EN1_PLL_BIT]; // see [RQ11]
  end

  // clock-source select is a pin of this block, passed as the timing mux control
  assign timing_from_pll = clk_source_sel; // see [RQ17]

  // read channel: one read at a time, data registered
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `PDC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= idx_known(addr_to_idx(s_axi_araddr)) ? `PDC_RESP_OKAY : `PDC_RESP_SLVERR;
      unique case (addr_to_idx(s_axi_araddr))
        `PDC_IDX_REF_LOW:    rdata_q <= {24'h000000, ref_low_q};
        `PDC_IDX_OUT_REF_HI: rdata_q <= {24'h000000, out_ref_hi_q};
        `PDC_IDX_PRE_LOW:    rdata_q <= {24'h000000, pre_low_q};
        `PDC_IDX_PRE_HI:     rdata_q <= {24'h000000, pre_hi_q};
        `PDC_IDX_PUMP:       rdata_q <= {24'h000000, pump_q};
        `PDC_IDX_EN1:        rdata_q <= {24'h000000, en1_q};
        `PDC_IDX_RES:        rdata_q <= {24'h000000, res_q};
        `PDC_IDX_CAP3:       rdata_q <= {24'h000000, cap3_q};
        // status: effective feedback ratio high, effective reference ratio low
        `PDC_IDX_STATUS:     rdata_q <= {4'h0, pll_cfg.fb_ratio, 6'h00, pll_cfg.ref_ratio};
        default:             rdata_q <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule

// file: tb/pdc_assertions.sv
// port checks for the pll configuration bank
// assumes binding onto pdc_pll_config_bank, one clock aclk
module pdc_assertions (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              clk_source_sel,
  input wire pdc_pkg::pdc_cfg_t pll_cfg,
  input wire logic              timing_from_pll
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // handshake steps
  sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_r_stall; s_axi_rvalid && !s_axi_rready; endsequence
  sequence s_b_stall; s_axi_bvalid && !s_axi_bready; endsequence
  chk_read_latency: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rdata_stands: assert property (s_r_stall |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_bresp_stands: assert property (s_b_stall |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_timing_src: assert property (timing_from_pll == clk_source_sel)
    else $error("timing source wrong");
  chk_bypass_one: assert property (pll_cfg.ref_bypass |-> pll_cfg.ref_ratio == 10'h001)
    else $error("bypass ratio not one");
  chk_ref_not_two: assert property (pll_cfg.ref_ratio != 10'h002)
    else $error("reference ratio two");
  chk_fb_nonzero: assert property (pll_cfg.fb_ratio != 12'h000)
    else $error("feedback ratio zero");
  // config may only move while a write answer is up or in the cycle after it drops
  chk_cfg_quiet: assert property (!s_axi_bvalid && !$past(s_axi_bvalid) |-> $stable(pll_cfg))
    else $error("config moved without write");
endmodule

bind pdc_pll_config_bank pdc_assertions chk_u (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .clk_source_sel, .pll_cfg, .timing_from_pll);

// file: tb/tb_top.sv
// self-checking bench for the pll configuration bank
// assumes pdc_pkg compiled first and the checker bound in
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = '0, aresetn = '0, clk_source_sel = '0, timing_from_pll;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = '0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  pdc_pkg::pdc_cfg_t pll_cfg;
  int          fails = 0, tests_run = 0;
  logic [7:0]  m[8];
  logic [9:0]  m_ref;

  pdc_pll_config_bank dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .clk_source_sel, .pll_cfg, .timing_from_pll);

  // 50 mhz clock
  always #10 aclk = ~aclk;

  task automatic chk_word(input logic [31:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_cfg(input pdc_pkg::pdc_cfg_t got, exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t config got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // write cycle; bready held back for stall cycles to test response holding
  task automatic wr_chk(input logic [7:0] idx, input logic [31:0] d, input int stall,
                        input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (stall == 0);
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && n > stall && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 40);
    chk_word({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // read cycle with optional rready stall
  task automatic rd_chk(input logic [7:0] idx, input int stall, input logic [31:0] ed,
                        input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (stall == 0);
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && n > stall && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
    chk_word(s_axi_rdata, ed, "read data");
    chk_word({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // expected decode; code 2 leaves the held ratio alone
  function automatic pdc_pkg::pdc_cfg_t exp_cfg();
    pdc_pkg::pdc_cfg_t c;
    logic [11:0] pre;
    pre = {m[3][3:0], m[2]};
    c.ref_bypass = !m[5][4];
    c.ref_ratio = c.ref_bypass ? 10'h1 : m_ref;
    c.vco_post_ratio = m[1][7:4];
    c.fb_ratio = (pre < 12'h2) ? 12'h1 : pre;
    c.bias_self = m[4][4];
    c.pump_current_code = m[4][3:0];
    c.filter_resistor_code = m[6][4:0];
    c.series_cap_code = m[7][4:0];
    c.pll_on = m[5][1];
    return c;
  endfunction

  // reset for 12 cycles, then every byte and the decode at defaults
  task automatic t_reset();
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    m = '{8'h00, 8'h44, 8'h78, 8'h40, 8'h12, 8'h41, 8'h2f, 8'h27};
    m_ref = 10'h1;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) rd_chk(8'h54 + 8'(i), 0, {24'h0, m[i]}, 2'h0);
    chk_cfg(pll_cfg, exp_cfg());
  endtask

  // field walk; factory bits kept, junk above bit 7 ignored
  task automatic t_fields();
    logic [7:0] wi[20] = '{8'h59, 8'h54, 8'h55, 8'h55, 8'h54, 8'h54, 8'h54, 8'h54, 8'h55,
      8'h55, 8'h56, 8'h57, 8'h56, 8'h57, 8'h56, 8'h58, 8'h5a, 8'h5b, 8'h59, 8'h58};
    logic [7:0] wd[20] = '{8'h53, 8'hff, 8'h47, 8'h44, 8'h02, 8'h01, 8'h00, 8'h03, 8'hf4,
      8'h04, 8'hff, 8'h4f, 8'h00, 8'h40, 8'h02, 8'h0f, 8'hbf, 8'ha0, 8'hc1, 8'h10};
    logic [9:0] code;
    foreach (wi[i]) begin
      wr_chk(wi[i], {24'ha5a5a5, wd[i]}, i % 3, 2'h0);
      m[wi[i] - 8'h54] = (wi[i] > 8'h58) ? (wd[i] & 8'h7f) : wd[i];
      code = {m[1][1:0], m[0]};
      if (code != 10'h2) m_ref = (code < 10'h2) ? 10'h1 : code;
      rd_chk(wi[i], i % 2, {24'h0, m[wi[i] - 8'h54]}, 2'h0);
      chk_cfg(pll_cfg, exp_cfg());
    end
  endtask

  // unmapped places refused, timing source follows select
  task automatic t_misc();
    pdc_pkg::pdc_cfg_t c;
    c = exp_cfg();
    rd_chk(8'h60, 0, {4'h0, c.fb_ratio, 6'h00, c.ref_ratio}, 2'h0);
    wr_chk(8'h50, 32'h55, 0, 2'h2);
    rd_chk(8'h50, 1, 32'h0, 2'h2);
    wr_chk(8'h60, 32'h55, 1, 2'h2);
    chk_cfg(pll_cfg, exp_cfg());
    for (int s = 0; s < 2; s++) begin
      clk_source_sel <= s[0];
      @(posedge aclk);
      chk_word({31'h0, timing_from_pll}, {31'h0, s[0]}, "timing source");
    end
  endtask

  // main sequence, second reset at the end
  initial begin
    t_reset();
    t_fields();
    t_misc();
    t_reset();
    report_and_stop();
  end

  // watchdog: run needs well under 2000 cycles
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule
